// >>> hw/audio_rx_pkg.sv
package audio_rx_pkg;
    // Register byte addresses
    localparam logic [31:0] TXDAT_ADDR = 32'h00218000;
    localparam logic [31:0] RXDAT_ADDR = 32'h00218004;
    localparam logic [31:0] CSR_ADDR   = 32'h00218008;
    localparam logic [31:0] CFG_ADDR   = 32'h0021800C;
    localparam logic [31:0] CCR_ADDR   = 32'h00218010;
    // Control and status field positions
    localparam int CSR_SHARED = 12;
    localparam int CSR_MSLOT  = 11;
    localparam int CSR_RXON   = 10;
    localparam int CSR_PEN    = 8;
    localparam int CSR_RDR    = 7;
    localparam int CSR_TDE    = 6;
    localparam int CSR_ROE    = 5;
    localparam int CSR_TUE    = 4;
    localparam int CSR_TFS    = 3;
    localparam int CSR_RFS    = 2;
    localparam int CSR_RFF    = 1;
    localparam int CSR_TFE    = 0;
    localparam logic [15:0] CSR_RESET = 16'h0041;
    // Receive configuration field positions
    localparam int CFG_FEN   = 0;
    localparam int CFG_IEN   = 1;
    localparam int CFG_SHD   = 2;
    localparam int CFG_BPOS  = 3;
    localparam int CFG_GATED = 4;
    localparam int CFG_THR   = 8;
    localparam logic [3:0] THR_RESET = 4'h8;
    localparam logic [1:0] WL_RESET  = 2'h3;
    // FIFO geometry
    localparam int FIFO_DEPTH = 8;
    localparam int WORD_W     = 16;

    typedef struct packed {
        logic clk;
        logic fs;
        logic dat;
    } link_s;

    typedef struct packed {
        logic       fen;
        logic       ien;
        logic       shd;
        logic       bpos;
        logic       gated;
        logic [3:0] thr;
    } rx_cfg_s;

    typedef enum logic {RX_IDLE, RX_SHIFT} rx_state_e;

    // Word length code to bit count: 8, 10, 12, 16
    function automatic logic [4:0] word_bits(input logic [1:0] code);
        case (code)
            2'h0:    word_bits = 5'h08;
            2'h1:    word_bits = 5'h0A;
            2'h2:    word_bits = 5'h0C;
            default: word_bits = 5'h10;
        endcase
    endfunction
endpackage

// >>> hw/audio_rx.sv
`timescale 1ns/1ps
// What this block does
// R1 - Received words wait in an eight-entry 16-bit FIFO; oldest is read first.
// R2 - FIFO works only while rx_fifo_enable is set; otherwise one word holds.
// R3 - With irq enable, interrupt when FIFO word count reaches the threshold.
// R4 - New words are discarded while the FIFO is full, until software reads.
// R5 - Serial bits collect in a 16-bit shift register, then move into the FIFO.
// R6 - Continuous clock: sample data on selected clock only while frame sync high.
// R7 - Gated clock: sample one bit on each rising edge of the selected clock, no frame sync.
// R8 - word_length codes 00..11 choose 8, 10, 12 or 16 bits per word.
// R9 - Short words have all unreceived positions filled with zeros.
// R10 - Position 0, direction 0: first bit at 15, last at 8/6/4/0.
// R11 - Position 0, direction 1: first bit at 8/6/4/0, last at 15.
// R12 - Position 1, direction 0: first bit at 0, last at 7/9/11/15.
// R13 - Position 1, direction 1: first bit at 7/9/11/15, last at 0.
// R14 - Status flags refresh on enable, then after first bit of each word.
// R15 - Overrun clears only after status read followed by receive data read.
// R16 - Underrun clears only after status read followed by transmit data write.
// R17 - Status register bits 31..16 always read zero.
// R18 - Bits 15..8 are writable controls; bits 7..0 are read-only flags.
// R19 - With irq enable, interrupt on every word moved into the FIFO.
// R20 - Shared clock mode makes receive use transmit clock and frame sync.
// R21 - multi_slot_mode bit selects normal (0) or network (1) operation; this block only stores it.
// R22 - Threshold comes from configuration; empty-FIFO reads leave the FIFO unchanged.
// R23 - Status register resets with only the two transmit-empty flags set.
module audio_rx (
    input  wire logic        CLOCK,
    input  wire logic        RESETN,
    input  wire logic [31:0] AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        RX_BIT_CLK,
    input  wire logic        RX_FRAME_SYNC,
    input  wire logic        TX_BIT_CLK,
    input  wire logic        TX_FRAME_SYNC,
    input  wire logic        SERIAL_DATA_IN_PIN,
    input  wire logic        TX_EMPTY,
    input  wire logic        TX_FIFO_EMPTY,
    input  wire logic        TX_UNDERRUN,
    output logic             IRQ
);
    localparam int DEPTH = audio_rx_pkg::FIFO_DEPTH;
    localparam int W     = audio_rx_pkg::WORD_W;

    // Link pins pass two flops before use
    audio_rx_pkg::link_s rx_s1_reg, rx_s2_reg, tx_s1_reg, tx_s2_reg;
    logic                prev_clk_reg;
    audio_rx_pkg::link_s sel;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            rx_s1_reg <= '0;
            rx_s2_reg <= '0;
            tx_s1_reg <= '0;
            tx_s2_reg <= '0;
        end else begin
            rx_s1_reg <= '{RX_BIT_CLK, RX_FRAME_SYNC, SERIAL_DATA_IN_PIN};
            tx_s1_reg <= '{TX_BIT_CLK, TX_FRAME_SYNC, 1'b0};
            rx_s2_reg <= rx_s1_reg;
            tx_s2_reg <= tx_s1_reg;
        end
    end

    // Registers seen by software
    logic [7:0]              ctrl_reg;
    audio_rx_pkg::rx_cfg_s   cfg_reg;
    logic [1:0]              wl_reg;
    logic [7:0]              stat_reg;
    logic                    roe_reg, tue_reg, roe_arm_reg, tue_arm_reg;
    logic                    pen_prev_reg, irq_reg;
    logic [31:0]             rdata_reg;
    logic                    wait_reg;

    wire pen    = ctrl_reg[audio_rx_pkg::CSR_PEN - 8];
    wire rx_on  = ctrl_reg[audio_rx_pkg::CSR_RXON - 8];
    wire shared = ctrl_reg[audio_rx_pkg::CSR_SHARED - 8];

    // Shared mode borrows the transmit clock and frame sync
    assign sel = shared ? audio_rx_pkg::link_s'{tx_s2_reg.clk, tx_s2_reg.fs, rx_s2_reg.dat}
                        : rx_s2_reg; // R20

    // Resets low like the idle link clock, so no false edge follows reset
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) prev_clk_reg <= 1'b0;
        else         prev_clk_reg <= sel.clk;
    end

    // Gated mode needs no frame sync; continuous mode does
    wire clk_rise = sel.clk && !prev_clk_reg;
    wire sample   = clk_rise && pen && rx_on
                    && (cfg_reg.gated || sel.fs); // R6 R7

    // Bus decode; an access completes in the cycle waitrequest is low
    wire req      = AVS_READ || AVS_WRITE;
    wire acc      = req && !wait_reg;
    wire hit_csr  = AVS_ADDRESS == audio_rx_pkg::CSR_ADDR;
    wire hit_rx   = AVS_ADDRESS == audio_rx_pkg::RXDAT_ADDR;
    wire hit_tx   = AVS_ADDRESS == audio_rx_pkg::TXDAT_ADDR;
    wire hit_cfg  = AVS_ADDRESS == audio_rx_pkg::CFG_ADDR;
    wire hit_ccr  = AVS_ADDRESS == audio_rx_pkg::CCR_ADDR;
    wire rd_csr   = acc && AVS_READ && hit_csr;
    wire rd_rx    = acc && AVS_READ && hit_rx;
    wire wr_tx    = acc && AVS_WRITE && hit_tx;

    // Receive shifter
    audio_rx_pkg::rx_state_e state_reg;
    logic [W-1:0]            shift_reg;
    logic [4:0]              bit_cnt_reg;
    wire  [4:0]              nbits = audio_rx_pkg::word_bits(wl_reg); // R8
    wire                     last  = sample && (bit_cnt_reg == nbits - 5'h01);
    wire  [W-1:0]            raw   = {shift_reg[W-2:0], sel.dat};

    // Bits arrive first-in at the top of raw; place per position and direction
    function automatic logic [W-1:0] rev(input logic [W-1:0] v);
        for (int i = 0; i < W; i++) rev[i] = v[W-1-i];
    endfunction

    wire [3:0]   pad     = 4'(5'h10 - nbits);
    wire [W-1:0] top     = raw << pad;    // Zero fill below the last bit
    wire [W-1:0] placed  = !cfg_reg.bpos ? (!cfg_reg.shd ? top          // R10 R9
                                                         : rev(top) << pad) // R11
                                         : (!cfg_reg.shd ? rev(top)     // R12
                                                         : raw & ~({W{1'b1}} << nbits)); // R13

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg   <= audio_rx_pkg::RX_IDLE;
            shift_reg   <= '0;
            bit_cnt_reg <= '0;
        end else if (!pen || !rx_on) begin
            state_reg   <= audio_rx_pkg::RX_IDLE;
            bit_cnt_reg <= '0;
        end else if (sample) begin
            shift_reg <= raw; // R5
            case (state_reg)
                audio_rx_pkg::RX_IDLE: begin
                    state_reg   <= audio_rx_pkg::RX_SHIFT;
                    bit_cnt_reg <= 5'h01;
                end
                audio_rx_pkg::RX_SHIFT: begin
                    bit_cnt_reg <= last ? 5'h00 : bit_cnt_reg + 5'h01;
                    if (last) state_reg <= audio_rx_pkg::RX_IDLE;
                end
                default: state_reg <= audio_rx_pkg::RX_IDLE;
            endcase
        end
    end

    // Receive FIFO; disabled FIFO behaves as a single holding word
    logic [W-1:0] mem [DEPTH];
    logic [2:0]   wr_ptr_reg, rd_ptr_reg;
    logic [3:0]   cnt_reg;
    wire  [3:0]   cap     = cfg_reg.fen ? 4'(DEPTH) : 4'h1; // R2
    wire          full    = cnt_reg >= cap;
    wire          pop     = rd_rx && cnt_reg != 4'h0; // R22
    wire          push_rq = sample && (bit_cnt_reg == nbits - 5'h01);
    wire          push    = push_rq && (!full || pop);  // R4
    // Threshold 0 keeps the flag set; its encoding is left to the integrator
    wire          rx_fifo_full_flag     = cfg_reg.fen ? cnt_reg >= cfg_reg.thr : full; // R22

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 3'h1;
            if (pop)  rd_ptr_reg <= rd_ptr_reg + 3'h1;
            cnt_reg <= cnt_reg + 4'(push) - 4'(pop); // R1
        end
    end

    // Storage without reset keeps it a plain memory
    always_ff @(posedge CLOCK) begin
        if (push) mem[wr_ptr_reg] <= placed; // R1 R5
    end

    // Status refresh on enable and after each word's first bit
    wire refresh = (pen && !pen_prev_reg)
                   || (sample && bit_cnt_reg == 5'h00); // R14

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            stat_reg     <= audio_rx_pkg::CSR_RESET[7:0]; // R23
            pen_prev_reg <= 1'b0;
        end else begin
            pen_prev_reg <= pen;
            if (refresh) begin
                stat_reg[audio_rx_pkg::CSR_RDR] <= cnt_reg != 4'h0;
                stat_reg[audio_rx_pkg::CSR_TDE] <= TX_EMPTY;
                stat_reg[audio_rx_pkg::CSR_TFS] <= tx_s2_reg.fs;
                stat_reg[audio_rx_pkg::CSR_RFS] <= sel.fs;
                stat_reg[audio_rx_pkg::CSR_RFF] <= rx_fifo_full_flag;
                stat_reg[audio_rx_pkg::CSR_TFE] <= TX_FIFO_EMPTY;
            end
        end
    end

    // Error flags: a status read arms the clear, the data access completes it.
    // A new error in the clearing cycle wins, so none is lost.
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            roe_reg     <= 1'b0;
            tue_reg     <= 1'b0;
            roe_arm_reg <= 1'b0;
            tue_arm_reg <= 1'b0;
        end else begin
            roe_arm_reg <= rd_csr || (roe_arm_reg && !rd_rx);
            tue_arm_reg <= rd_csr || (tue_arm_reg && !wr_tx);
            if (push_rq && full && !pop)  roe_reg <= 1'b1; // R4
            else if (roe_arm_reg && rd_rx) roe_reg <= 1'b0; // R15
            if (TX_UNDERRUN)               tue_reg <= 1'b1;
            else if (tue_arm_reg && wr_tx) tue_reg <= 1'b0; // R16
        end
    end

    // Writable control and configuration
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_reg <= audio_rx_pkg::CSR_RESET[15:8];
            cfg_reg  <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, audio_rx_pkg::THR_RESET};
            wl_reg   <= audio_rx_pkg::WL_RESET;
        end else if (acc && AVS_WRITE) begin
            // multi_slot_mode is stored for software; slot timing lies outside this block
            if (hit_csr) ctrl_reg <= AVS_WRITEDATA[15:8]; // R18 R21
            if (hit_cfg) cfg_reg  <= '{AVS_WRITEDATA[audio_rx_pkg::CFG_FEN],
                                       AVS_WRITEDATA[audio_rx_pkg::CFG_IEN],
                                       AVS_WRITEDATA[audio_rx_pkg::CFG_SHD],
                                       AVS_WRITEDATA[audio_rx_pkg::CFG_BPOS],
                                       AVS_WRITEDATA[audio_rx_pkg::CFG_GATED],
                                       AVS_WRITEDATA[audio_rx_pkg::CFG_THR +: 4]};
            if (hit_ccr) wl_reg   <= AVS_WRITEDATA[1:0];
        end
    end

    // Read mux; error flags are live, the rest come from the snapshot
    wire [7:0]  flags = {stat_reg[7:6], roe_reg, tue_reg, stat_reg[3:0]};
    wire [31:0] csr_q = {16'h0000, ctrl_reg, flags}; // R17 R18
    wire [31:0] cfg_q = {20'h00000, cfg_reg.thr, 3'h0, cfg_reg.gated,
                         cfg_reg.bpos, cfg_reg.shd, cfg_reg.ien, cfg_reg.fen};
    wire [31:0] rx_q  = {16'h0000, cnt_reg != 4'h0 ? mem[rd_ptr_reg] : 16'h0000};
    wire [31:0] rd_q  = hit_csr ? csr_q
                      : hit_rx  ? rx_q
                      : hit_cfg ? cfg_q
                      : hit_ccr ? {30'h00000000, wl_reg}
                      : 32'h00000000;

    // One wait cycle per access; read data are set up during it
    // An access thus takes two cycles, and a pop lands on the completing edge
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            wait_reg  <= 1'b1;
            rdata_reg <= '0;
        end else begin
            wait_reg <= !(req && wait_reg);
            if (req && wait_reg) rdata_reg <= AVS_READ ? rd_q : 32'h00000000;
        end
    end

    // Interrupt on threshold or on each stored word
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) irq_reg <= 1'b0;
        else         irq_reg <= cfg_reg.ien && (rx_fifo_full_flag || push); // R3 R19
    end

    assign AVS_READDATA    = rdata_reg;
    assign AVS_WAITREQUEST = wait_reg;
    assign IRQ             = irq_reg;

    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);

    // FIFO occupancy, overflow and interrupts

    AST_FIFO_BOUND: assert property (cnt_reg <= cap) // R1
        else $error("fifo count above capacity");
    AST_SINGLE_WORD: assert property (!cfg_reg.fen && push |-> cnt_reg == 4'h0 || pop) // R2
        else $error("disabled fifo stored a second word");
    AST_THR_IRQ: assert property (cfg_reg.ien && cfg_reg.fen && cnt_reg >= cfg_reg.thr // R3
                                  |=> IRQ)
        else $error("threshold irq missing");
    AST_WORD_IRQ: assert property (cfg_reg.ien && push |=> IRQ) // R19
        else $error("word irq missing");
    AST_IRQ_OFF: assert property (!cfg_reg.ien |=> !IRQ) // R3
        else $error("irq raised while disabled");
    AST_DROP: assert property (push_rq && full && !pop // R4
                               |=> cnt_reg == $past(cnt_reg) && roe_reg)
        else $error("word not dropped on full fifo");
    AST_PUSH: assert property (push && !pop |=> cnt_reg == $past(cnt_reg) + 4'h1) // R5
        else $error("word not stored");
    AST_CNT_POP: assert property (pop && !push |=> cnt_reg == $past(cnt_reg) - 4'h1) // R1
        else $error("read did not free an entry");
    AST_EMPTY_READ: assert property (rd_rx && cnt_reg == 4'h0 && !push_rq // R22
                                     |=> cnt_reg == 4'h0 && $stable(rd_ptr_reg))
        else $error("empty read changed fifo");

    // Link sampling, word length and placement
    AST_NO_FS: assert property (!cfg_reg.gated && clk_rise && !sel.fs // R6
                                |=> $stable(bit_cnt_reg))
        else $error("sampled without frame sync");
    AST_GATED: assert property (cfg_reg.gated && clk_rise && pen && rx_on // R7
                                |=> bit_cnt_reg != $past(bit_cnt_reg))
        else $error("gated edge not sampled");
    AST_IDLE_CNT: assert property (!(pen && rx_on) |=> bit_cnt_reg == 5'h00) // R6
        else $error("bit counter kept while receiver off");
    AST_FILL: assert property (push && wl_reg == 2'h0 && !cfg_reg.bpos // R9
                               |-> placed[7:0] == 8'h00)
        else $error("short word not zero filled");

    // Register side: reserved bits, snapshots, error clearing, wait state
    AST_UPPER: assert property (AVS_READ && !wait_reg && hit_csr // R17
                                |-> AVS_READDATA[31:16] == 16'h0000)
        else $error("reserved status bits not zero");
    AST_RX_HIGH: assert property (AVS_READ && !wait_reg && hit_rx // R1
                                  |-> AVS_READDATA[31:16] == 16'h0000)
        else $error("receive data upper half not zero");
    AST_REFRESH: assert property (pen && !pen_prev_reg |=> // R14
                                  stat_reg[audio_rx_pkg::CSR_TFE] == $past(TX_FIFO_EMPTY))
        else $error("status not refreshed on enable");
    AST_STAT_HOLD: assert property (!refresh |=> $stable(stat_reg)) // R14
        else $error("status changed between refreshes");
    AST_ROE_HOLD: assert property (roe_reg && !(roe_arm_reg && rd_rx) |=> roe_reg) // R15
        else $error("overrun cleared early");
    AST_TUE_HOLD: assert property (tue_reg && !(tue_arm_reg && wr_tx) |=> tue_reg) // R16
        else $error("underrun cleared early");
    AST_ROE_CLEAR: assert property (roe_arm_reg && rd_rx && !(push_rq && full && !pop) // R15
                                    |=> !roe_reg)
        else $error("overrun not cleared");
    AST_TUE_CLEAR: assert property (tue_arm_reg && wr_tx && !TX_UNDERRUN |=> !tue_reg) // R16
        else $error("underrun not cleared");
    AST_WAIT_ONE: assert property (req && wait_reg |=> !wait_reg ##1 wait_reg)
        else $error("wait cycle not one");
    AST_WAIT_REST: assert property (!req |=> AVS_WAITREQUEST)
        else $error("waitrequest low without request");

    COV_FULL:  cover property (cfg_reg.fen && cnt_reg == 4'(DEPTH));
    COV_DROP:  cover property (push_rq && full);
    COV_CLEAR: cover property (roe_reg ##1 !roe_reg);
    COV_IRQ:   cover property (IRQ);
    COV_GATED: cover property (cfg_reg.gated && push);
endmodule // audio_rx

// >>> tb/serial_source.sv
`timescale 1ns/1ps
// Serial audio source on the far side of the receive pin set
module serial_source (
    input  wire logic          clk,
    output audio_rx_pkg::link_s lnk
);
    // Clock stands low between frames; the model never runs it free
    initial lnk = '0;

    // One word, first bit first, 80 ns bit period (10 system clocks per half)
    task automatic send(input int n, input logic [15:0] v, input logic use_fs);
        for (int k = 0; k < n; k++) begin
            lnk.dat <= v[n-1-k];
            lnk.fs  <= use_fs;
            repeat (10) @(posedge clk);
            lnk.clk <= 1'b1;
            repeat (10) @(posedge clk);
            lnk.clk <= 1'b0;
        end
        // Released line shows the inverse so a stale value is not mistaken for data
        lnk.fs  <= 1'b0;
        lnk.dat <= ~v[0];
        repeat (20) @(posedge clk);
    endtask
endmodule // serial_source

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic                clock    = 1'b0;
    logic                resetn   = 1'b0;
    logic [31:0]         address  = 32'h0;
    logic                rd       = 1'b0;
    logic                wr       = 1'b0;
    logic [31:0]         wdata    = 32'h0;
    logic                shared   = 1'b0;
    logic                tx_empty = 1'b0;
    logic                underrun = 1'b0;
    logic                tx_fifo_e = 1'b1;
    logic                irq_d    = 1'b0;
    logic [31:0]         rdata;
    logic                waitreq;
    logic                irq;
    logic [31:0]         q;
    logic [15:0]         v;
    logic [15:0]         exp_q[$];
    audio_rx_pkg::link_s lnk;
    int                  nb[4] = '{8, 10, 12, 16};
    int                  n_fail = 0;
    int                  checks = 0;
    int                  n_irq  = 0;
    int                  base   = 0;
    int                  cap    = 8;

    always #2 clock = ~clock;

    // Rising interrupt edges; each stored word raises one
    always @(posedge clock) begin
        irq_d <= irq;
        if (irq === 1'b1 && irq_d !== 1'b1)
            n_irq <= n_irq + 1;
    end

    serial_source u_src (.clk(clock), .lnk(lnk));

    // Shared mode moves the source clock and sync onto the transmit pins
    audio_rx u_dut (
        .CLOCK(clock), .RESETN(resetn), .AVS_ADDRESS(address), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .RX_BIT_CLK(lnk.clk & ~shared),
        .RX_FRAME_SYNC(lnk.fs & ~shared), .TX_BIT_CLK(lnk.clk & shared),
        .TX_FRAME_SYNC(lnk.fs & shared), .SERIAL_DATA_IN_PIN(lnk.dat),
        .TX_EMPTY(tx_empty), .TX_FIFO_EMPTY(tx_fifo_e), .TX_UNDERRUN(underrun), .IRQ(irq)
    );

    task automatic give_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Avalon master: hold until waitrequest low, take data there, idle one edge
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        wr      <= w;
        rd      <= ~w;
        wdata   <= d;
        do begin
            @(posedge clock);
            n++;
        end while (waitreq !== 1'b0 && n < 64);
        if (n >= 64)
            n_fail++;
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clock);
    endtask

    // Threshold 8 in bits 11:8, fifo enable in bit 0
    function automatic logic [31:0] cfgw(logic ien, logic dir, logic pos, logic gated);
        cfgw = 32'h00000801 | (32'(ien) << audio_rx_pkg::CFG_IEN)
             | (32'(dir) << audio_rx_pkg::CFG_SHD) | (32'(pos) << audio_rx_pkg::CFG_BPOS)
             | (32'(gated) << audio_rx_pkg::CFG_GATED);
    endfunction

    // Reference placement of bit k (k = 0 arrives first) for an n-bit word
    function automatic logic [15:0] place(int n, logic [15:0] d, logic pos, logic dir);
        place = 16'h0000;
        for (int k = 0; k < n; k++)
            place[pos ? (dir ? n-1-k : k) : (dir ? 16-n+k : 15-k)] = d[n-1-k];
    endfunction

    // Model keeps at most cap words; later ones are lost
    task automatic rx_word(int n, logic pos, logic dir, logic use_fs);
        v = 16'($urandom) >> (16 - n);
        u_src.send(n, v, use_fs);
        if (exp_q.size() < cap)
            exp_q.push_back(place(n, v, pos, dir));
    endtask

    // Watchdog, well past the expected run length
    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end

    initial begin
        void'($urandom(95750));
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        bus(1'b0, audio_rx_pkg::CSR_ADDR, 32'h0);
        chk("status reset", q, 32'h00000041);
        tx_empty  <= 1'($urandom);
        tx_fifo_e <= 1'($urandom);
        bus(1'b0, 32'h00218020, 32'h0);
        chk("unmapped", q, 32'h0);
        bus(1'b0, audio_rx_pkg::RXDAT_ADDR, 32'h0);
        chk("empty read", q, 32'h0);
        bus(1'b1, audio_rx_pkg::CSR_ADDR, 32'hFFFF05FF);
        bus(1'b0, audio_rx_pkg::CSR_ADDR, 32'h0);
        chk("controls", q & 32'hFFFFFF00, 32'h00000500);
        chk("refresh", q & 32'h00000061, {25'h0, tx_empty, 5'h0, tx_fifo_e});
        // Every word length against every placement
        for (int wl = 0; wl < 4; wl++) begin
            for (int m = 0; m < 4; m++) begin
                bus(1'b1, audio_rx_pkg::CCR_ADDR, 32'(wl));
                bus(1'b1, audio_rx_pkg::CFG_ADDR, cfgw(1'b0, m[0], m[1], 1'b0));
                rx_word(nb[wl], m[1], m[0], 1'b1);
                bus(1'b0, audio_rx_pkg::RXDAT_ADDR, 32'h0);
                chk("word", q, {16'h0, exp_q.pop_front()});
            end
        end
        // Overfill by one word with the interrupt on
        bus(1'b1, audio_rx_pkg::CFG_ADDR, cfgw(1'b1, 1'b0, 1'b0, 1'b0));
        base = n_irq;
        repeat (9) rx_word(16, 1'b0, 1'b0, 1'b1);
        chk("irq full", {31'h0, irq}, 32'h1);
        chk("irq words", 32'(n_irq - base), 32'h00000008);
        bus(1'b0, audio_rx_pkg::CSR_ADDR, 32'h0);
        chk("full overrun", q & 32'h00000022, 32'h00000022);
        repeat (8) begin
            bus(1'b0, audio_rx_pkg::RXDAT_ADDR, 32'h0);
            chk("fifo", q, {16'h0, exp_q.pop_front()});
        end
        bus(1'b0, audio_rx_pkg::CSR_ADDR, 32'h0);
        chk("overrun clear", q & 32'h00000020, 32'h0);
        chk("irq low", {31'h0, irq}, 32'h0);
        bus(1'b0, audio_rx_pkg::RXDAT_ADDR, 32'h0);
        chk("drained", q, 32'h0);
        // Disabled fifo keeps one word; a second is lost
        cap = 1;
        bus(1'b1, audio_rx_pkg::CFG_ADDR, 32'h00000800);
        repeat (2) rx_word(16, 1'b0, 1'b0, 1'b1);
        repeat (2) begin
            bus(1'b0, audio_rx_pkg::RXDAT_ADDR, 32'h0);
            chk("one word", q, {16'h0, (exp_q.size() > 0) ? exp_q.pop_front() : 16'h0});
        end
        cap = 8;
        // Gated clock needs no sync; continuous clock without sync takes nothing
        bus(1'b1, audio_rx_pkg::CFG_ADDR, cfgw(1'b0, 1'b0, 1'b0, 1'b1));
        rx_word(16, 1'b0, 1'b0, 1'b0);
        bus(1'b0, audio_rx_pkg::RXDAT_ADDR, 32'h0);
        chk("gated", q, {16'h0, exp_q.pop_front()});
        bus(1'b1, audio_rx_pkg::CFG_ADDR, cfgw(1'b0, 1'b0, 1'b0, 1'b0));
        u_src.send(16, 16'hA5C3, 1'b0);
        bus(1'b0, audio_rx_pkg::RXDAT_ADDR, 32'h0);
        chk("no sync", q, 32'h0);
        // Shared clock mode uses the transmit pins
        shared <= 1'b1;
        bus(1'b1, audio_rx_pkg::CSR_ADDR, 32'h00001D00);
        bus(1'b0, audio_rx_pkg::CSR_ADDR, 32'h0);
        chk("slot mode", q & 32'h0000FF00, 32'h00001D00);
        rx_word(16, 1'b0, 1'b0, 1'b1);
        bus(1'b0, audio_rx_pkg::RXDAT_ADDR, 32'h0);
        chk("shared", q, {16'h0, exp_q.pop_front()});
        // Underrun clears by status read then transmit write
        underrun <= 1'b1;
        @(posedge clock);
        underrun <= 1'b0;
        bus(1'b0, audio_rx_pkg::CSR_ADDR, 32'h0);
        chk("underrun", q & 32'h00000010, 32'h00000010);
        bus(1'b1, audio_rx_pkg::TXDAT_ADDR, 32'h00001234);
        bus(1'b0, audio_rx_pkg::CSR_ADDR, 32'h0);
        chk("underrun clear", q & 32'h00000010, 32'h0);
        give_verdict();
    end
endmodule // testbench
